/* common/lmon_pkg.sv */
// Purpose: Shared constants for the optical link monitor.
// Assumes: 125 MHz reference clock, APB with 32-bit data.
// Notes:   Rate codes select the optical bit period.
package lmon_pkg;

  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned STRETCH_MS  = 300;
  localparam int unsigned STRETCH_CYC = CLK_HZ / 1000 * STRETCH_MS;
  localparam int unsigned ACK_BITS    = 11;
  localparam int unsigned END_BITS    = 2;
  localparam int unsigned ACK_PULSE_BITS = 1;
  localparam int unsigned LOW_NUM     = 14;
  localparam int unsigned LOW_DEN     = 10;
  localparam int unsigned BITCYC_W    = 18;
  localparam int unsigned TOCYC_W     = 20;
  localparam int unsigned REGEN_STAGES = 2;

  localparam logic [11:0] OFS_CTRL  = 12'h000;
  localparam logic [11:0] OFS_STAT  = 12'h004;
  localparam logic [11:0] OFS_LEVEL = 12'h008;

  localparam int unsigned CTRL_RATE_LSB = 0;
  localparam int unsigned CTRL_ACK_BIT  = 4;
  localparam int unsigned CTRL_EN_LSB   = 8;
  localparam logic [2:0]  RATE_RST      = 3'h6;
  localparam int unsigned NUM_EV        = 4;
  localparam int unsigned EV_LOW = 0;
  localparam int unsigned EV_EXT = 1;
  localparam int unsigned EV_RXA = 2;
  localparam int unsigned EV_ACK = 3;

  localparam int unsigned ST_TXLED_BIT = 8;
  localparam int unsigned ST_RXLED_BIT = 9;
  localparam int unsigned ST_OPEN_BIT  = 4;

  // Bit period in clock cycles for each rate code
  function automatic logic [BITCYC_W-1:0] lmon_bit_cyc(input logic [2:0] code);
    int unsigned bps;
    case (code)
      3'h0:    bps = 9600;
      3'h1:    bps = 19200;
      3'h2:    bps = 45450;
      3'h3:    bps = 93750;
      3'h4:    bps = 187500;
      3'h5:    bps = 500000;
      default: bps = 1500000;
    endcase
    return BITCYC_W'(CLK_HZ / bps);
  endfunction

endpackage

/* core/lmon_stretch.sv */
// Purpose: Bank of retriggerable pulse stretchers.
// Assumes: Triggers are synchronous one-cycle or level events.
// Notes:   Output stays high CYC cycles after the last trigger.
`timescale 1ns/1ps
module lmon_stretch #(
  parameter int unsigned CYC = 16,
  parameter int unsigned N   = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [N-1:0] trig_i,
  output logic      [N-1:0] busy_o
);
  localparam int unsigned CW = $clog2(CYC + 1);
  // Loading CYC itself keeps the output high for exactly CYC cycles
  localparam logic [CW-1:0] LOAD = CW'(CYC);

  if (CYC < 2) begin : g_bad_cyc
    $error("lmon_stretch: CYC must be at least 2");
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_st
      logic [CW-1:0] cnt_r;
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          cnt_r     <= '0;
          busy_o[g] <= 1'b0;
        end else if (trig_i[g]) begin
          cnt_r     <= LOAD;
          busy_o[g] <= 1'b1;
        end else if (cnt_r != '0) begin
          cnt_r     <= cnt_r - 1'b1;
          busy_o[g] <= (cnt_r != CW'(1));
        end else begin
          busy_o[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

/* core/lmon_core.sv */
// Purpose: Supervision and signal path of an infrared fieldbus link converter.
// Assumes: Pins are synchronous to ref_clk_i; optical and bus idle level is 1.
// Notes:   Registers on APB; zero-wait answers, unmapped offsets give pslverr.
`timescale 1ns/1ps
module lmon_core
  import lmon_pkg::*;
#(
  parameter int unsigned LVL_W     = 10,
  parameter int unsigned MIN_LEVEL = 100,
  parameter int unsigned HOLD_CYC  = STRETCH_CYC
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [11:0]      paddr_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [31:0]      pwdata_i,
  input  wire logic [3:0]       pstrb_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  input  wire logic             opt_rx_i,
  output logic                  opt_tx_o,
  input  wire logic             elec_tx_i,
  output logic                  elec_rx_o,
  output logic                  elec_den_o,
  input  wire logic [LVL_W-1:0] rx_level_i,
  input  wire logic             ext_light_i,
  output logic                  led_low_o,
  output logic                  led_err_o,
  output logic                  led_rx_o,
  output logic                  led_tx_yel_o,
  output logic                  led_tx_org_o,
  output logic                  contact_closed_o
);

  localparam logic [LVL_W-1:0] LOW_THR = LVL_W'(MIN_LEVEL * LOW_NUM / LOW_DEN);

  if (MIN_LEVEL * LOW_NUM / LOW_DEN >= (1 << LVL_W)) begin : g_bad_thr
    $error("lmon_core: threshold does not fit LVL_W");
  end
  if (HOLD_CYC < 2) begin : g_bad_hold
    $error("lmon_core: HOLD_CYC too small");
  end

  typedef enum logic [2:0] {
    LM_IDLE,
    LM_TX_FRAME,
    LM_WAIT_ACK,
    LM_RX_FRAME,
    LM_SEND_ACK,
    LM_ACK_TAIL
  } lmon_state_t;

  // Configuration and bus registers
  logic [2:0]        rate_r;
  logic              ack_en_r;
  logic [NUM_EV-1:0] ev_en_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;

  // Link state
  lmon_state_t         state_r;
  lmon_state_t         state_nxt;
  logic [TOCYC_W-1:0]  cnt_r;
  logic [TOCYC_W-1:0]  cnt_nxt;
  logic [BITCYC_W-1:0] bit_cyc_r;
  logic [TOCYC_W-1:0]  end_cyc_r;
  logic [TOCYC_W-1:0]  ack_to_r;
  logic                opt_rx_q;
  logic                opt_tx_r;
  logic                elec_rx_r;
  logic                elec_den_r;
  logic [REGEN_STAGES-1:0] rx_pipe_r;
  logic [REGEN_STAGES-1:0] tx_pipe_r;
  logic [LVL_W-1:0]    level_r;

  // Events and indicators
  logic              weak_r;
  logic              ext_r;
  logic              ack_ok_r;
  logic              ack_miss_r;
  logic              open_r;
  logic              closed_r;
  logic [3:0]        st_trig;
  logic [3:0]        st_busy;

  // APB decode
  wire setup     = psel_i & ~penable_i;
  wire wr_commit = psel_i & penable_i & pready_r & pwrite_i;
  wire hit_ctrl  = (paddr_i == OFS_CTRL);
  wire hit_stat  = (paddr_i == OFS_STAT);
  wire hit_level = (paddr_i == OFS_LEVEL);
  wire hit_any   = hit_ctrl | hit_stat | hit_level;

  wire [31:0] ctrl_word = {16'h0000, 4'h0, ev_en_r, 3'h0, ack_en_r, 1'b0, rate_r};
  wire [31:0] stat_word = {22'h0, st_busy[1], st_busy[0], 3'h0, open_r,
                           st_busy[2], ~st_busy[3], ext_r, weak_r};
  wire [31:0] lvl_word  = {{(32 - LVL_W){1'b0}}, level_r};
  wire [31:0] rd_mux    = hit_ctrl ? ctrl_word :
                          hit_stat ? stat_word :
                          hit_level ? lvl_word : 32'h0000_0000;

  // Link edges
  wire rx_edge  = opt_rx_i ^ opt_rx_q;
  wire tx_start = ~elec_tx_i;
  wire rx_start = ~opt_rx_i;

  // Stretcher triggers: tx lamp, rx lamp, missing ack, receive watchdog
  wire tx_act   = (state_r == LM_TX_FRAME) & (elec_tx_i ^ tx_pipe_r[0]);
  wire rx_act   = rx_edge & ((state_r == LM_RX_FRAME) | ((state_r == LM_IDLE) & rx_start & ~tx_start));
  assign st_trig = {rx_edge, ack_miss_r, rx_act, tx_act | ack_ok_r};

  lmon_stretch #(
    .CYC (HOLD_CYC),
    .N   (4)
  ) u_stretch (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .trig_i    (st_trig),
    .busy_o    (st_busy)
  );

  // Conditions feeding the contact
  wire low_now  = (state_r == LM_RX_FRAME) & (rx_level_i < LOW_THR);
  wire rxa_flt  = ~st_busy[3];
  wire ack_flt  = st_busy[2] & ack_en_r;
  wire [NUM_EV-1:0] ev_vec;
  assign ev_vec[EV_LOW] = weak_r;
  assign ev_vec[EV_EXT] = ext_r;
  assign ev_vec[EV_RXA] = rxa_flt;
  assign ev_vec[EV_ACK] = ack_flt;
  wire fault_any = |(ev_vec & ev_en_r);

  // Register write path; bytes 0 and 1 of CTRL are writable
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rate_r   <= RATE_RST;
      ack_en_r <= 1'b0;
      ev_en_r  <= '0;
    end else if (wr_commit && hit_ctrl) begin
      if (pstrb_i[0]) begin
        rate_r   <= pwdata_i[CTRL_RATE_LSB +: 3];
        ack_en_r <= pwdata_i[CTRL_ACK_BIT];
      end
      if (pstrb_i[1]) begin
        ev_en_r <= pwdata_i[CTRL_EN_LSB +: NUM_EV];
      end
    end
  end

  // Answer in the first access cycle, no wait states
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit_any;
      if (setup) begin
        prdata_r <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Timing derived from the rate switch
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cyc_r <= '0;
      end_cyc_r <= '0;
      ack_to_r  <= '0;
    end else begin
      bit_cyc_r <= lmon_bit_cyc(rate_r);
      end_cyc_r <= TOCYC_W'(bit_cyc_r * END_BITS);
      ack_to_r  <= TOCYC_W'(bit_cyc_r * ACK_BITS);
    end
  end

  // Link sequencer. A frame ends after END_BITS of idle line.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      LM_IDLE: begin
        cnt_nxt = '0;
        if (tx_start) begin
          state_nxt = LM_TX_FRAME;
        end else if (rx_start) begin
          state_nxt = LM_RX_FRAME;
        end
      end
      LM_TX_FRAME: begin
        cnt_nxt = elec_tx_i ? cnt_r + 1'b1 : '0;
        if (elec_tx_i && cnt_r >= end_cyc_r) begin
          cnt_nxt   = '0;
          state_nxt = ack_en_r ? LM_WAIT_ACK : LM_IDLE;
        end
      end
      LM_WAIT_ACK: begin
        cnt_nxt = cnt_r + 1'b1;
        if (rx_start) begin
          cnt_nxt   = '0;
          state_nxt = LM_ACK_TAIL;
        end else if (cnt_r >= ack_to_r) begin
          cnt_nxt   = '0;
          state_nxt = LM_IDLE;
        end
      end
      // Swallow the rest of the ack pulse so it never opens a receive frame
      LM_ACK_TAIL: begin
        cnt_nxt = '0;
        if (opt_rx_i) begin
          state_nxt = LM_IDLE;
        end
      end
      LM_RX_FRAME: begin
        cnt_nxt = opt_rx_i ? cnt_r + 1'b1 : '0;
        if (opt_rx_i && cnt_r >= end_cyc_r) begin
          cnt_nxt   = '0;
          state_nxt = ack_en_r ? LM_SEND_ACK : LM_IDLE;
        end
      end
      LM_SEND_ACK: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r >= TOCYC_W'(bit_cyc_r * ACK_PULSE_BITS)) begin
          cnt_nxt   = '0;
          state_nxt = LM_IDLE;
        end
      end
      default: begin
        state_nxt = LM_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= LM_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  wire ack_seen = (state_r == LM_WAIT_ACK) & rx_start;
  wire ack_lost = (state_r == LM_WAIT_ACK) & ~rx_start & (cnt_r >= ack_to_r);

  // Fixed-latency retiming of both directions; the pipe squares the edges up
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      opt_rx_q  <= 1'b1;
      rx_pipe_r <= '1;
      tx_pipe_r <= '1;
    end else begin
      opt_rx_q  <= opt_rx_i;
      rx_pipe_r <= {opt_rx_i, rx_pipe_r[REGEN_STAGES-1:1]};
      tx_pipe_r <= {elec_tx_i, tx_pipe_r[REGEN_STAGES-1:1]};
    end
  end

  // Ack traffic is kept off the electrical side in both directions
  wire rx_fwd   = (state_r == LM_RX_FRAME);
  wire tx_fwd   = (state_r == LM_TX_FRAME);
  wire ack_drv  = (state_r == LM_SEND_ACK);
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      opt_tx_r   <= 1'b1;
      elec_rx_r  <= 1'b1;
      elec_den_r <= 1'b0;
    end else begin
      opt_tx_r   <= ack_drv ? 1'b0 : (tx_fwd ? tx_pipe_r[0] : 1'b1);
      elec_rx_r  <= rx_fwd ? rx_pipe_r[0] : 1'b1;
      elec_den_r <= rx_fwd;
    end
  end

  // Condition flags and contact; contact opens while a fault is selected
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      weak_r     <= 1'b0;
      ext_r      <= 1'b0;
      ack_ok_r   <= 1'b0;
      ack_miss_r <= 1'b0;
      level_r    <= '0;
      open_r     <= 1'b0;
      closed_r   <= 1'b1;
    end else begin
      weak_r     <= low_now;
      ext_r      <= ext_light_i;
      ack_ok_r   <= ack_seen;
      ack_miss_r <= ack_lost;
      open_r     <= fault_any;
      closed_r   <= ~fault_any;
      if (rx_fwd) begin
        level_r <= rx_level_i;
      end
    end
  end

  // Lamps. Orange overrides yellow while a lost ack is being shown.
  logic led_low_r;
  logic led_err_r;
  logic led_rx_r;
  logic led_yel_r;
  logic led_org_r;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led_low_r <= 1'b0;
      led_err_r <= 1'b0;
      led_rx_r  <= 1'b0;
      led_yel_r <= 1'b0;
      led_org_r <= 1'b0;
    end else begin
      led_low_r <= weak_r;
      led_err_r <= ext_r;
      led_rx_r  <= st_busy[1];
      led_yel_r <= (st_busy[0] | ack_ok_r) & ~ack_flt;
      led_org_r <= ack_flt;
    end
  end

  assign prdata_o         = prdata_r;
  assign pready_o         = pready_r;
  assign pslverr_o        = pslverr_r;
  assign opt_tx_o         = opt_tx_r;
  assign elec_rx_o        = elec_rx_r;
  assign elec_den_o       = elec_den_r;
  assign led_low_o        = led_low_r;
  assign led_err_o        = led_err_r;
  assign led_rx_o         = led_rx_r;
  assign led_tx_yel_o     = led_yel_r;
  assign led_tx_org_o     = led_org_r;
  assign contact_closed_o = closed_r;

endmodule

/* tb/lmon_core_sva.sv */
// Purpose: Port-level checks of the link monitor core.
// Assumes: Switch settings are shadowed from APB writes to CTRL.
// Notes:   Contact path latency is two cycles, so windows allow three.
`timescale 1ns/1ps
module lmon_core_sva
  import lmon_pkg::*;
#(
  parameter int unsigned HOLD_CYC = 200
) (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic [11:0] paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        opt_rx_i,
  input wire logic        elec_tx_i,
  input wire logic        elec_rx_o,
  input wire logic        elec_den_o,
  input wire logic        ext_light_i,
  input wire logic        led_err_o,
  input wire logic        led_rx_o,
  input wire logic        led_tx_yel_o,
  input wire logic        led_tx_org_o,
  input wire logic        contact_closed_o
);
  logic [3:0]  en_r;
  logic        ack_r;
  logic        rx_q_r;
  int unsigned idle_r;
  wire         wr_ctrl = psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFS_CTRL;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_r   <= 4'h0;
      ack_r  <= 1'b0;
      rx_q_r <= 1'b1;
      idle_r <= 0;
    end else begin
      rx_q_r <= opt_rx_i;
      if (opt_rx_i != rx_q_r)
        idle_r <= 0;
      else if (idle_r < HOLD_CYC + 8)
        idle_r <= idle_r + 1;
      if (wr_ctrl) begin
        en_r  <= pwdata_i[11:8];
        ack_r <= pwdata_i[CTRL_ACK_BIT];
      end
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  property p_ext_open;
    (ext_light_i && en_r[EV_EXT])[*3] |-> !contact_closed_o;
  endproperty
  a_ext_open: assert property (p_ext_open) else $error("contact closed under light");
  property p_err_led;
    ext_light_i[*3] |-> led_err_o;
  endproperty
  a_err_led: assert property (p_err_led) else $error("error lamp dark");
  property p_none_closed;
    (en_r == 4'h0)[*3] |-> contact_closed_o;
  endproperty
  a_none_closed: assert property (p_none_closed) else $error("contact open with no enable");
  property p_ack_gate;
    (en_r == 4'h8 && !ack_r)[*3] |-> contact_closed_o;
  endproperty
  a_ack_gate: assert property (p_ack_gate) else $error("ack fault without ack mode");
  property p_rx_lamp;
    $rose(elec_den_o) |-> ##[0:3] led_rx_o;
  endproperty
  a_rx_lamp: assert property (p_rx_lamp) else $error("rx lamp dark");
  property p_tx_lamp;
    $fell(elec_tx_i) && !elec_den_o |-> ##[1:4] (led_tx_yel_o || led_tx_org_o);
  endproperty
  a_tx_lamp: assert property (p_tx_lamp) else $error("tx lamp dark");
  property p_regen;
    $fell(elec_rx_o) |-> !($past(opt_rx_i, 2) && $past(opt_rx_i, 3) && $past(opt_rx_i, 4));
  endproperty
  a_regen: assert property (p_regen) else $error("bus low without optical cause");
  property p_rx_dog;
    (en_r[EV_RXA] && idle_r >= HOLD_CYC + 4)[*3] |-> !contact_closed_o;
  endproperty
  a_rx_dog: assert property (p_rx_dog) else $error("silent link left contact closed");
  property p_org_hold;
    $rose(led_tx_org_o) |-> ack_r ##1 led_tx_org_o[*8];
  endproperty
  a_org_hold: assert property (p_org_hold) else $error("orange lamp wrong");
endmodule

bind lmon_core lmon_core_sva #(.HOLD_CYC(HOLD_CYC)) u_sva (.*);

/* tb/lmon_partner.sv */
// Purpose: Behavioural partner converter across the optical path.
// Assumes: Bit period and ack mode are set alike on both ends.
// Notes:   Idle optical level is 1; frames are start, 8 data, stop.
`timescale 1ns/1ps
module lmon_partner (
  input  wire logic        clk_i,
  input  wire logic        opt_i,
  input  wire logic        ack_en_i,
  input  wire logic        drop_ack_i,
  input  wire logic [15:0] bit_i,
  input  wire logic [15:0] ack_dly_i,
  input  wire logic        send_i,
  input  wire logic [7:0]  byte_i,
  output logic             opt_o,
  output logic             busy_o,
  output logic [7:0]       acks_o
);
  logic snd_r = 1'b1;
  logic ackp_r = 1'b1;
  bit   prev;
  bit   got;
  int   hi;
  assign opt_o = snd_r & ackp_r;
  initial begin
    busy_o = 1'b0;
    acks_o = 8'h00;
    forever begin
      @(posedge clk_i);
      if (send_i) begin
        busy_o <= 1'b1;
        for (int i = 0; i < 10; i++) begin
          snd_r <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : byte_i[i-1];
          repeat (bit_i) @(posedge clk_i);
        end
        prev = 1'b1;
        // Count returned pulses; the far end owes one within 11 bits
        for (int i = 0; i < 13 * bit_i; i++) begin
          @(posedge clk_i);
          if (!opt_i && prev)
            acks_o <= acks_o + 8'h01;
          prev = opt_i;
        end
        busy_o <= 1'b0;
      end
    end
  end
  // Answer a received frame once the line is idle for two bits
  initial begin
    forever begin
      @(posedge clk_i);
      hi = opt_i ? hi + 1 : 0;
      if (!opt_i && !busy_o)
        got = 1'b1;
      if (got && hi >= 2 * bit_i) begin
        got = 1'b0;
        if (ack_en_i && !drop_ack_i) begin
          repeat (ack_dly_i) @(posedge clk_i);
          ackp_r <= 1'b0;
          repeat (bit_i) @(posedge clk_i);
          ackp_r <= 1'b1;
        end
      end
    end
  end
endmodule

/* tb/lmon_core_tb.sv */
// Purpose: Self-checking bench for the link monitor core.
// Assumes: Lamp hold shortened to HOLD cycles.
// Notes:   Read results are queued by the driver and checked by a monitor.
`timescale 1ns/1ps
module lmon_core_tb;
  import lmon_pkg::*;
  localparam int unsigned HOLD = 200;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  pstrb_i = 4'hf;
  logic        elec_tx_i = 1'b1;
  logic        ext_light_i = 1'b0;
  logic [9:0]  rx_level_i = 10'h000;
  logic        send = 1'b0, pack = 1'b0, drop = 1'b0;
  logic [7:0]  sbyte = 8'h00;
  logic [15:0] dly = 16'h0000;
  logic [2:0]  rate = 3'h6;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, opt_rx_i, opt_tx_o, elec_rx_o, elec_den_o, led_low_o, led_err_o;
  logic        led_rx_o, led_tx_yel_o, led_tx_org_o, contact_closed_o, pbusy;
  logic [7:0]  acks;
  logic [32:0] exp_q[$];
  int          bc = 83, num_errors = 0, compares = 0, n, rx_low, rx_lows = 0;
  lmon_core #(.HOLD_CYC(HOLD)) DUT (.*);
  lmon_partner u_far (.clk_i(ref_clk_i), .opt_i(opt_tx_o), .ack_en_i(pack), .drop_ack_i(drop), .bit_i(16'(bc)),
    .ack_dly_i(dly), .send_i(send), .byte_i(sbyte), .opt_o(opt_rx_i), .busy_o(pbusy), .acks_o(acks));
  always #4 ref_clk_i = ~ref_clk_i;
  // Counts cycles with the electrical receive line low
  always @(posedge ref_clk_i)
    if (!elec_rx_o)
      rx_lows <= rx_lows + 1;
  always @(posedge ref_clk_i)
    if (psel_i && penable_i && pready_o && !pwrite_i)
      chk({pslverr_o, prdata_o}, exp_q.pop_front());
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] d);
    if (!w)
      exp_q.push_back(d);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d[31:0];
    cyc(1);
    penable_i <= 1'b1;
    do
      cyc(1);
    while (!pready_o);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    cyc(1);
  endtask
  task automatic wctrl(input logic [3:0] en, input logic ack);
    apb(1'b1, OFS_CTRL, {21'h0, en, 3'h0, ack, 1'b0, rate});
  endtask
  // Odd data bits kept 0 so no run of ones looks like the gap between frames
  task automatic efr;
    logic [7:0] b;
    b = 8'($urandom) & 8'h55;
    for (int i = 0; i < 10; i++) begin
      elec_tx_i <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      cyc(bc);
    end
  endtask
  task automatic pfr(input logic [7:0] b);
    sbyte <= b & 8'h55;
    send  <= 1'b1;
    cyc(1);
    send <= 1'b0;
    cyc(1);
    while (pbusy)
      cyc(1);
  endtask
  task automatic tally_and_finish;
    $display("mismatches=%0d comparisons=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #600us;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'he670));
    cyc(4);
    rstn_i <= 1'b1;
    cyc(2);
    apb(1'b0, OFS_CTRL, 33'h6);
    apb(1'b0, OFS_STAT, 33'h4);
    apb(1'b0, 12'h00c, 33'h1_0000_0000);
    chk(contact_closed_o, 1);
    ext_light_i <= 1'b1;
    cyc(4);
    chk(led_err_o, 1);
    chk(contact_closed_o, 1);
    wctrl(4'h2, 1'b0);
    apb(1'b0, OFS_CTRL, 33'h206);
    chk(contact_closed_o, 0);
    ext_light_i <= 1'b0;
    wctrl(4'h4, 1'b0);
    cyc(HOLD + 10);
    chk(contact_closed_o, 0);
    fork
      pfr(8'h55);
    join_none
    cyc(6 * bc);
    chk(contact_closed_o, 1);
    while (pbusy)
      cyc(1);
    wctrl(4'h1, 1'b0);
    // Weak level is random below the threshold, then exactly on it
    for (int k = 0; k < 2; k++) begin
      n = k ? 140 : $urandom_range(139, 0);
      rx_level_i <= 10'(n);
      rx_low = rx_lows;
      fork
        pfr(8'($urandom));
      join_none
      cyc(5 * bc);
      chk(led_low_o, k == 0);
      chk(contact_closed_o, 33'(k));
      while (pbusy)
        cyc(1);
      chk(rx_lows != rx_low, 1);
      apb(1'b0, OFS_LEVEL, 33'(n));
    end
    for (int r = 0; r < 2; r++) begin
      rate = r ? 3'h5 : 3'h6;
      bc = r ? 250 : 83;
      pack <= 1'b1;
      drop <= 1'b0;
      dly <= 16'(11 * bc - 20);
      wctrl(4'h8, 1'b1);
      rx_low = rx_lows;
      efr();
      cyc(12 * bc);
      chk(led_tx_yel_o, 1);
      cyc(3 * bc);
      chk(led_tx_org_o, 0);
      chk(rx_lows != rx_low, 0);
      drop <= 1'b1;
      efr();
      n = 0;
      while (!led_tx_org_o && n < 20 * bc) begin
        cyc(1);
        n++;
      end
      chk(n >= 12 * bc - 2 && n <= 12 * bc + 12, 1);
      cyc(3);
      chk(contact_closed_o, 0);
      cyc(HOLD - 20);
      chk(led_tx_org_o, 1);
      cyc(30);
      chk(led_tx_org_o, 0);
      chk(contact_closed_o, 1);
      drop <= 1'b0;
      n = acks;
      pfr(8'($urandom));
      chk(acks, 33'(n + 1));
    end
    pack <= 1'b0;
    wctrl(4'h8, 1'b0);
    efr();
    cyc(16 * bc);
    chk(led_tx_org_o, 0);
    chk(contact_closed_o, 1);
    tally_and_finish;
  end
endmodule
